// file: src/commutation_blanking_deadtime.sv
// Position blanking latches, commutation decode and cross-conduction lockout with APB access.
// Assumes sensor and oscillator inputs synchronous to pclk; fault_reset from UV/fault logic.
module commutation_blanking_deadtime
  import commutation_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        position_sensor_1,
  input  wire logic        position_sensor_2,
  input  wire logic        position_sensor_3,
  input  wire logic        osc_clk,
  input  wire logic        fault_reset,
  input  wire logic        current_sense_pos,
  input  wire logic        current_sense_neg,
  output logic             sense_active,
  output logic             tach_out,
  output logic [2:0]       low_side_drive,
  output logic [2:0]       high_side_drive
);
  typedef enum logic [0:0] {OPEN, BLANK} latch_state_t;

  latch_state_t st_q, st_d;
  logic [2:0]  pos_q, pos_d;
  logic [1:0]  blank_q, blank_d;
  logic [15:0] tach_cnt_q, tach_cnt_d;
  logic [15:0] tach_len_q, tach_len_d;
  logic [2:0]  ctrl_q, ctrl_d;
  logic        osc_q;
  logic [2:0]  lo_q, hi_q;
  logic [31:0] prdata_q, prdata_d;
  logic        sense_q;
  logic [2:0]  lo_req, hi_req, lo_en, hi_en;
  logic [5:0]  lock;
  logic        osc_rise, clear, changed, tach_busy, acc, wr;
  logic [2:0]  sensors;

  assign sensors  = {position_sensor_3, position_sensor_2, position_sensor_1};
  assign osc_rise = osc_clk && !osc_q;
  assign clear    = fault_reset || ctrl_q[CTRL_FAULT];
  assign tach_busy = tach_cnt_q != 16'h0000;
  assign changed  = sensors != pos_q;
  assign acc      = psel && penable;
  assign wr       = acc && pwrite;

  // Returns {high, low} one-hot, phase A in bit 0; never the same phase on both sides
  function automatic logic [5:0] commutate(input logic [2:0] h, input logic dir);
    logic [5:0] r;
    r = 6'h00;
    unique case ({dir, h[0], h[1], h[2]})
      4'b1001: r = {3'b001, 3'b010};
      4'b1011: r = {3'b001, 3'b100};
      4'b1010: r = {3'b010, 3'b100};
      4'b1110: r = {3'b010, 3'b001};
      4'b1100: r = {3'b100, 3'b001};
      4'b1101: r = {3'b100, 3'b010};
      4'b0101: r = {3'b010, 3'b100};
      4'b0100: r = {3'b001, 3'b100};
      4'b0110: r = {3'b001, 3'b010};
      4'b0010: r = {3'b100, 3'b010};
      4'b0011: r = {3'b100, 3'b001};
      4'b0001: r = {3'b010, 3'b001};
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  // Table gives high-side on as pin low; here 1 means that high driver is on
  always_comb begin
    logic [5:0] c;
    c = commutate(pos_q, ctrl_q[CTRL_DIR]);
    lo_req = c[2:0];
    hi_req = c[5:3];
  end

  always_comb begin
    st_d       = st_q;
    pos_d      = pos_q;
    blank_d    = blank_q;
    tach_cnt_d = tach_cnt_q;
    if (tach_busy) begin
      tach_cnt_d = tach_cnt_q - 16'h0001;
    end
    unique case (st_q)
      OPEN: begin
        if (changed && !tach_busy) begin
          pos_d      = sensors;
          st_d       = BLANK;
          blank_d    = 2'h0;
          tach_cnt_d = tach_len_q;
        end
      end
      BLANK: begin
        if (osc_rise) begin
          if (blank_q == BLANK_PERIODS - 2'h1) begin
            st_d    = OPEN;
            blank_d = 2'h0;
          end else begin
            blank_d = blank_q + 2'h1;
          end
        end
      end
    endcase
    if (clear) begin
      st_d       = OPEN;
      blank_d    = 2'h0;
      tach_cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= OPEN;
      pos_q      <= 3'h0;
      blank_q    <= 2'h0;
      tach_cnt_q <= 16'h0000;
      osc_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      pos_q      <= pos_d;
      blank_q    <= blank_d;
      tach_cnt_q <= tach_cnt_d;
      osc_q      <= osc_clk;
    end
  end

  // Opposing driver and its lock both gate; the lock lags its drive by one cycle
  assign lo_en = clear ? 3'h0 : (lo_req & ~(lock[5:3] | hi_q));
  assign hi_en = clear ? 3'h0 : (hi_req & ~(lock[2:0] | lo_q));

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      lockout_cell u_lo (
        .pclk       (pclk),
        .presetn    (presetn),
        .sync_clear (clear),
        .osc_rise   (osc_rise),
        .drive      (lo_q[g]),
        .lock       (lock[g])
      );
      lockout_cell u_hi (
        .pclk       (pclk),
        .presetn    (presetn),
        .sync_clear (clear),
        .osc_rise   (osc_rise),
        .drive      (hi_q[g]),
        .lock       (lock[g+3])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_q    <= 3'h0;
      hi_q    <= 3'h0;
      sense_q <= 1'b0;
    end else begin
      lo_q    <= lo_en;
      hi_q    <= hi_en;
      sense_q <= ctrl_q[CTRL_QUAD] ? (current_sense_pos ^ current_sense_neg) : current_sense_pos;
    end
  end

  always_comb begin
    ctrl_d     = ctrl_q;
    tach_len_d = tach_len_q;
    prdata_d   = prdata_q;
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL:     ctrl_d = pwdata[2:0];
        ADDR_TACH_LEN: tach_len_d = pwdata[15:0];
        default:       ctrl_d = ctrl_q;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL:     prdata_d = {29'h0, ctrl_q};
        ADDR_STATUS:   prdata_d = {18'h0, lock, hi_q, lo_q, tach_busy, st_q == BLANK};
        ADDR_TACH_LEN: prdata_d = {16'h0, tach_len_q};
        ADDR_POSITION: prdata_d = {29'h0, pos_q};
        default:       prdata_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= CTRL_RESET;
      tach_len_q <= TACH_LEN_RESET;
      prdata_q   <= 32'h0000_0000;
    end else begin
      ctrl_q     <= ctrl_d;
      tach_len_q <= tach_len_d;
      prdata_q   <= prdata_d;
    end
  end

  assign pready          = 1'b1;
  assign pslverr         = 1'b0;
  assign prdata          = prdata_q;
  assign low_side_drive  = lo_q;
  assign high_side_drive = hi_q;
  assign tach_out        = tach_busy;
  assign sense_active    = sense_q;

  sequence s_capture;
    st_q == OPEN && changed && !tach_busy && !clear;
  endsequence
  a_blank_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_capture |=> (st_q == BLANK && pos_q == $past(sensors)))
    else $error("position not captured");
  a_blank_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == BLANK) |=> (pos_q == $past(pos_q)))
    else $error("position moved while blanked");
  a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
    (lo_q & hi_q) == 3'h0)
    else $error("both drivers of a phase on");
  a_invalid_off: assert property (@(posedge pclk) disable iff (!presetn)
    (pos_q == 3'h0 || pos_q == 3'h7) |=> (lo_q == 3'h0 && hi_q == 3'h0))
    else $error("drive on for invalid code");
  a_tach_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_capture ##0 (tach_len_q != 16'h0000) |=> tach_out)
    else $error("tach pulse not started");
  a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> (st_q == OPEN && !tach_out))
    else $error("fault reset did not clear");
  a_onehot_drive: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(lo_q) && $onehot0(hi_q))
    else $error("more than one driver on a side");
  a_quad_abs: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[CTRL_QUAD] |=> sense_q == ($past(current_sense_pos) ^ $past(current_sense_neg)))
    else $error("four-quadrant sense wrong");
endmodule

// file: inc/commutation_pkg.sv
// Constants, encodings and register map of the commutation blanking and dead-time block.
// Assumes one pclk domain and an APB slave with 32-bit data.
package commutation_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_TACH_LEN  = 8'h08;
  localparam logic [7:0]  ADDR_POSITION  = 8'h0c;
  localparam int          CTRL_DIR       = 0;
  localparam int          CTRL_QUAD      = 1;
  localparam int          CTRL_FAULT     = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam logic [15:0] TACH_LEN_RESET = 16'h0010;
  localparam logic [1:0]  BLANK_PERIODS  = 2'h2;
  localparam logic [1:0]  DEAD_PERIODS   = 2'h2;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;
endpackage

// file: src/lockout_cell.sv
// One lockout flip-flop with its dead-time counter.
// Assumes osc_rise is a one-cycle pulse per oscillator period.
module lockout_cell
  import commutation_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sync_clear,
  input  wire logic osc_rise,
  input  wire logic drive,
  output logic      lock
);
  logic       lock_q, lock_d;
  logic [1:0] cnt_q, cnt_d;

  always_comb begin
    lock_d = lock_q;
    cnt_d  = cnt_q;
    // Set wins over clear so a driver still on never loses its lock
    if (drive) begin
      lock_d = 1'b1;
      cnt_d  = 2'h0;
    end else if (sync_clear) begin
      lock_d = 1'b0;
      cnt_d  = 2'h0;
    end else if (lock_q && osc_rise) begin
      if (cnt_q == DEAD_PERIODS - 2'h1) begin
        lock_d = 1'b0;
        cnt_d  = 2'h0;
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      cnt_q  <= 2'h0;
    end else begin
      lock_q <= lock_d;
      cnt_q  <= cnt_d;
    end
  end

  assign lock = lock_q;

  a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (lock_q && !drive && !sync_clear && !osc_rise) |=> lock_q)
    else $error("lockout dropped without oscillator edge");
  a_lock_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (drive && !sync_clear) |=> lock_q)
    else $error("lockout not set by drive");
endmodule

// file: testbench/hall_sensor_model.sv
// Position sensor stand-in driving the three sensor inputs.
// Assumes commands change just after pclk rising edges.
module hall_sensor_model (
  input  wire logic       pclk,
  input  wire logic [2:0] code,
  input  wire logic       bounce,
  output logic            position_sensor_1,
  output logic            position_sensor_2,
  output logic            position_sensor_3
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bounce flips sensor 1 for a cycle, as real sensors do near a transition
  always @(posedge pclk) begin
    {position_sensor_1, position_sensor_2, position_sensor_3} <= code ^ {bounce, 2'h0};
  end
endmodule

// file: testbench/commutation_blanking_deadtime_tb.sv
// Self-checking bench: sensor steps, dead time, tach width, sense mode, fault, APB.
// Assumes the design answers APB itself; osc_clk is made here at pclk/8.
module commutation_blanking_deadtime_tb import commutation_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_clk = 0, osc_p = 0;
  logic        fault_reset = 0, current_sense_pos = 0, current_sense_neg = 0, bounce = 0;
  logic        pready, pslverr, sense_active, tach_out;
  logic        position_sensor_1, position_sensor_2, position_sensor_3;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, got, exp_q [$];
  logic [2:0]  low_side_drive, high_side_drive, code = 3'h0, osc_cnt = 3'h0;
  int          errors = 0, comparisons = 0, hc [3] = '{9, 9, 9}, lc [3] = '{9, 9, 9};
  event        result_ev;
  // Index {dir, sensor 1..3}; value {high side, low side}, phase A in bit 0
  localparam logic [5:0] drive_tab [16] = '{6'h00, 6'h11, 6'h22, 6'h21, 6'h0c, 6'h14, 6'h0a, 6'h00,
                                            6'h00, 6'h0a, 6'h14, 6'h0c, 6'h21, 6'h22, 6'h11, 6'h00};
  commutation_blanking_deadtime i_commutation_blanking_deadtime (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .position_sensor_1, .position_sensor_2,
    .position_sensor_3, .osc_clk, .fault_reset, .current_sense_pos, .current_sense_neg,
    .sense_active, .tach_out, .low_side_drive, .high_side_drive);
  hall_sensor_model i_hall_sensor_model (.pclk, .code, .bounce, .position_sensor_1,
    .position_sensor_2, .position_sensor_3);
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc_clk <= osc_cnt[2];
  end
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic show(input logic [31:0] v);
    got = v;
    -> result_ev;
  endtask
  always @(result_ev) begin
    comparisons++;
    if (exp_q.size() == 0) bad("result without expectation");
    else if (exp_q.pop_front() !== got) bad($sformatf("result mismatch, got %h", got));
  end
  // Overlap and dead time, counted in oscillator rises since the opposing driver went off
  always @(posedge pclk) begin
    for (int p = 0; p < 3; p++) begin
      if ((low_side_drive[p] && hc[p] < 2) || (high_side_drive[p] && lc[p] < 2)) bad("dead time");
      hc[p] = high_side_drive[p] ? 0 : hc[p] + int'(osc_clk && !osc_p && hc[p] < 9);
      lc[p] = low_side_drive[p] ? 0 : lc[p] + int'(osc_clk && !osc_p && lc[p] < 9);
    end
    osc_p = osc_clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad("apb timeout");
      wrap_up();
    end
    if (pslverr !== 1'b0) bad("slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    exp_q.push_back(e);
    show(prdata);
  endtask
  // Waits out blanking, tach and dead time before sampling the drives
  task automatic step(input logic [2:0] c, input logic d);
    @(posedge pclk);
    code <= c;
    exp_q.push_back({26'h0, drive_tab[{d, c}]});
    repeat (60) @(posedge pclk);
    show({26'h0, high_side_drive, low_side_drive});
  endtask
  initial begin
    int   len, k, n;
    logic q, p, m;
    void'($urandom(2156));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_TACH_LEN, 32'h0000_0010);
    rd(8'h10, UNMAPPED_READ);
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, ADDR_CTRL, 32'(d));
      for (int c = 0; c < 8; c++) step(3'(c), 1'(d));
    end
    rd(ADDR_POSITION, 32'h0000_0007);
    rd(ADDR_STATUS, 32'h0000_0000);
    step(3'h0, 1'b1);
    @(posedge pclk);
    code <= 3'h3;
    exp_q.push_back({26'h0, drive_tab[4'hb]});
    repeat (4) @(posedge pclk);
    bounce <= 1'b1;
    @(posedge pclk);
    bounce <= 1'b0;
    repeat (6) @(posedge pclk);
    show({26'h0, high_side_drive, low_side_drive});
    // Let the bounce scenario's tach pulse end before timing a fresh one
    repeat (60) @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      len = 5 + $urandom % 20;
      apb(1'b1, ADDR_TACH_LEN, 32'(len));
      code <= 3'(4 + i);
      k = 0;
      n = 0;
      while (tach_out !== 1'b1 && k < 10) begin
        @(posedge pclk);
        k++;
      end
      while (tach_out === 1'b1 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      exp_q.push_back(32'(len));
      show(32'(n));
      repeat (60) @(posedge pclk);
    end
    for (int i = 0; i < 8; i++) begin
      q = i[2];
      p = 1'($urandom % 2);
      m = 1'($urandom % 2);
      apb(1'b1, ADDR_CTRL, {30'h0, q, 1'b1});
      current_sense_pos <= p;
      current_sense_neg <= m;
      repeat (3) @(posedge pclk);
      exp_q.push_back(32'(q ? p ^ m : p));
      show(32'(sense_active));
    end
    for (int i = 0; i < 2; i++) begin
      step(3'h1, 1'b1);
      if (i == 0) fault_reset <= 1'b1;
      else apb(1'b1, ADDR_CTRL, 32'h0000_0005);
      repeat (3) @(posedge pclk);
      exp_q.push_back(32'h0000_0000);
      show({26'h0, high_side_drive, low_side_drive});
      fault_reset <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      exp_q.push_back({26'h0, drive_tab[4'h9]});
      repeat (60) @(posedge pclk);
      show({26'h0, high_side_drive, low_side_drive});
    end
    rd(ADDR_STATUS, 32'h0000_0a28);
    repeat (8) begin
      q = 1'($urandom % 2);
      apb(1'b1, ADDR_CTRL, 32'(q));
      step(3'($urandom % 8), q);
    end
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    bad("run timeout");
    wrap_up();
  end
endmodule
